// ==== src/serial_port.sv ====
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Receive quiet low from start to stop
// - Word transfer sets ready, raises receive irq
// - Errors flagged with ready, same cycle
// - Ready clears after status, data read, empty
// - Transmit quiet when empty and not shifting
// - Status read then data write clears quiet
// - No transmit quiet while word/break queued
// - Holding empty set on shift load
// - Status read then data write clears empty
// - Transmitter enable sets holding empty
// - Unit off floats lines; on follows enables
// - Disable discards buffers, resets baud counter
// - Disable clears enables/flags, sets quiet flags
// - Disable aborts frames; re-enable keeps config
// - Bit 6 selects eight or nine bits
// - Bit 5 enables parity
// - Bit 4 selects odd parity
// - Bit 3 selects two stop bits
// - Break after buffered data, 13 bits min
// - Ninth bits: receive bit 1, transmit bit 0
// - Least significant bit first, baud timed
// - Status read then data access clears overrun; word errors clear on status read then data read
module serial_port
	import serial_port_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_in,
	output logic rx_in_used,
	output logic tx_out,
	output logic tx_oe,
	output logic irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] frame_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] baud_reg;
	logic tx_empty_reg, tx_quiet_reg, rx_quiet_reg, overrun_flag_reg;
	logic status_seen_reg;
	logic unit_on, tx_on, rx_on;
	logic wr_fire, rd_fire, wr_data, rd_data, rd_status;
	logic [3:0] aw_reg;
	logic aw_full_reg, w_full_reg;
	logic [7:0] wd_reg;
	logic wstrb0_reg;
	logic rx_push, rx_pop, rx_store, tx_load;
	rx_word_s rx_new;
	rx_word_s rx_mem [rx_depth];
	logic [1:0] rx_count_reg;
	logic rx_rd_ptr_reg;
	rx_word_s rx_head;
	logic [7:0] tx_hold_reg;
	logic tx_hold_ninth_reg;

	assign unit_on = frame_reg[unit_on_pos];
	assign tx_on = unit_on && ctrl2_reg[transmitter_on_pos];
	assign rx_on = unit_on && ctrl2_reg[receiver_on_pos];

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_data = wr_fire && aw_reg == data_addr && wstrb0_reg;
	assign rd_data = rd_fire && s_axi_araddr == data_addr;
	assign rd_status = rd_fire && s_axi_araddr == status_addr;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_reg <= 4'h0;
			wd_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				aw_reg <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				wd_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= resp_okay;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= resp_okay;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= resp_okay;
			case (s_axi_araddr[3:2])
				2'h0: s_axi_rdata <= {24'h0, rx_head.parity_err && rx_count_reg != 2'd0,
					rx_head.noise && rx_count_reg != 2'd0,
					rx_head.framing_err && rx_count_reg != 2'd0, overrun_flag_reg, rx_quiet_reg,
					rx_count_reg != 2'd0, tx_quiet_reg, tx_empty_reg};
				2'h1: s_axi_rdata <= {24'h0, frame_reg[7:2], rx_head.ninth && rx_count_reg != 2'd0, 1'b0};
				2'h2: s_axi_rdata <= {24'h0, ctrl2_reg};
				default: s_axi_rdata <= {24'h0, rx_head.data};
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frame_reg <= frame_ctrl_reset;
			ctrl2_reg <= second_ctrl_reset;
		end
		else
		begin
			if (wr_fire && wstrb0_reg && aw_reg == frame_ctrl_addr)
				frame_reg <= {wd_reg[7:2], 1'b0, wd_reg[tx_ninth_pos]};
			if (wr_fire && wstrb0_reg && aw_reg == second_ctrl_addr)
				ctrl2_reg <= wd_reg;
			if (!unit_on)
			begin
				frame_reg[send_break_pos] <= 1'b0;
				ctrl2_reg[transmitter_on_pos] <= 1'b0;
				ctrl2_reg[receiver_on_pos] <= 1'b0;
			end
		end
	end

	// Baud divisor fixed at its reset value, no register slot
	assign baud_reg = baud_reset;

	// ----------------------------------------
	// Baud tick generator
	// ----------------------------------------
	logic [13:0] baud_cnt_reg;
	logic [13:0] baud_div;
	logic baud_tick;
	assign baud_div = ctrl2_reg[high_speed_pos] ? 14'((int'(baud_reg) + 1) * high_speed_div)
		: 14'((int'(baud_reg) + 1) * low_speed_div);
	assign baud_tick = baud_cnt_reg == 14'(int'(baud_div) - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !unit_on || baud_tick)
			baud_cnt_reg <= 14'h0;
		else
			baud_cnt_reg <= baud_cnt_reg + 14'h1;
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	typedef enum logic [2:0] {tx_idle, tx_start, tx_bits, tx_par, tx_stop, tx_brk} tx_state_e;
	tx_state_e tx_state_reg;
	logic [8:0] tx_shift_reg;
	logic [4:0] tx_idx_reg;
	logic tx_par_reg;
	logic tx_full_reg;
	logic [3:0] data_bits;
	assign data_bits = frame_reg[nine_bit_pos] ? 4'd9 : 4'd8;
	assign tx_load = tx_state_reg == tx_idle && tx_full_reg && baud_tick;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_on)
		begin
			tx_state_reg <= tx_idle;
			tx_idx_reg <= 5'd0;
			tx_shift_reg <= 9'h0;
			tx_par_reg <= 1'b0;
			tx_out <= 1'b1;
		end
		else if (baud_tick)
		begin
			case (tx_state_reg)
				tx_idle:
				begin
					tx_out <= 1'b1;
					if (tx_full_reg)
					begin
						tx_shift_reg <= {tx_hold_ninth_reg, tx_hold_reg};
						tx_par_reg <= frame_reg[parity_odd_pos];
						tx_state_reg <= tx_start;
					end
					else if (frame_reg[send_break_pos])
					begin
						tx_idx_reg <= 5'd0;
						tx_state_reg <= tx_brk;
					end
				end
				tx_start:
				begin
					tx_out <= 1'b0;
					tx_idx_reg <= 5'd0;
					tx_state_reg <= tx_bits;
				end
				tx_bits:
				begin
					tx_out <= tx_shift_reg[0];
					tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
					tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
					tx_idx_reg <= tx_idx_reg + 5'd1;
					if (tx_idx_reg == 5'(data_bits - 4'd1))
						tx_state_reg <= frame_reg[parity_on_pos] ? tx_par : tx_stop;
				end
				tx_par:
				begin
					tx_out <= tx_par_reg;
					tx_idx_reg <= 5'd0;
					tx_state_reg <= tx_stop;
				end
				tx_stop:
				begin
					tx_out <= 1'b1;
					tx_idx_reg <= 5'd0;
					if (tx_state_reg == tx_stop && (!frame_reg[two_stop_pos] || tx_idx_reg == 5'd1))
						tx_state_reg <= tx_idle;
					else
						tx_idx_reg <= 5'd1;
				end
				tx_brk:
				begin
					// Line returns high on the tick that leaves the break
					tx_out <= tx_idx_reg >= 5'(break_bits) && !frame_reg[send_break_pos];
					if (tx_idx_reg < 5'(break_bits))
						tx_idx_reg <= tx_idx_reg + 5'd1;
					else if (!frame_reg[send_break_pos])
						tx_state_reg <= tx_idle;
				end
				default: tx_state_reg <= tx_idle;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_on)
		begin
			tx_full_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
			tx_hold_ninth_reg <= 1'b0;
		end
		else if (wr_data)
		begin
			tx_full_reg <= 1'b1;
			tx_hold_reg <= wd_reg;
			tx_hold_ninth_reg <= frame_reg[tx_ninth_pos];
		end
		else if (tx_load)
			tx_full_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !tx_on)
		begin
			tx_empty_reg <= 1'b1;
			tx_quiet_reg <= 1'b1;
		end
		else
		begin
			if (tx_load)
				tx_empty_reg <= 1'b1;
			else if (wr_data && status_seen_reg)
				tx_empty_reg <= 1'b0;
			if (wr_data && status_seen_reg)
				tx_quiet_reg <= 1'b0;
			else if (tx_full_reg || frame_reg[send_break_pos] || tx_state_reg != tx_idle)
				tx_quiet_reg <= 1'b0;
			else if (tx_empty_reg)
				tx_quiet_reg <= 1'b1;
		end
	end

	// Status read arms the clearing sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_seen_reg <= 1'b0;
		else if (rd_status)
			status_seen_reg <= 1'b1;
		else if (rd_data || wr_data)
			status_seen_reg <= 1'b0;
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	typedef enum logic [2:0] {rx_wait, rx_start, rx_bits, rx_par, rx_stop} rx_state_e;
	rx_state_e rx_state_reg;
	logic [8:0] rx_shift_reg;
	logic [4:0] rx_idx_reg;
	logic rx_par_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_on)
		begin
			rx_state_reg <= rx_wait;
			rx_quiet_reg <= 1'b1;
			rx_idx_reg <= 5'd0;
			rx_shift_reg <= 9'h0;
			rx_par_reg <= 1'b0;
		end
		else if (baud_tick)
		begin
			case (rx_state_reg)
				rx_wait:
					if (!rx_in)
					begin
						rx_quiet_reg <= 1'b0;
						rx_state_reg <= rx_bits;
						rx_idx_reg <= 5'd0;
						rx_par_reg <= frame_reg[parity_odd_pos];
					end
				rx_bits:
				begin
					rx_shift_reg <= frame_reg[nine_bit_pos] ? {rx_in, rx_shift_reg[8:1]}
						: {1'b0, rx_in, rx_shift_reg[7:1]};
					rx_par_reg <= rx_par_reg ^ rx_in;
					rx_idx_reg <= rx_idx_reg + 5'd1;
					if (rx_idx_reg == 5'(data_bits - 4'd1))
						rx_state_reg <= frame_reg[parity_on_pos] ? rx_par : rx_stop;
				end
				rx_par:
				begin
					rx_par_reg <= rx_par_reg ^ rx_in;
					rx_state_reg <= rx_stop;
				end
				rx_stop:
				begin
					rx_quiet_reg <= 1'b1;
					rx_state_reg <= rx_wait;
				end
				default: rx_state_reg <= rx_wait;
			endcase
		end
	end

	assign rx_push = baud_tick && rx_on && rx_state_reg == rx_stop;
	assign rx_new = '{parity_err: frame_reg[parity_on_pos] && rx_par_reg, noise: 1'b0,
		framing_err: !rx_in, ninth: rx_shift_reg[8], data: rx_shift_reg[7:0]};
	assign rx_pop = rd_data && status_seen_reg && rx_count_reg != 2'd0;
	// Full buffer still stores when the head is popped in the same cycle
	assign rx_store = rx_push && (rx_count_reg != 2'(rx_depth) || rx_pop);
	assign rx_head = rx_mem[rx_rd_ptr_reg];

	always_ff @(posedge aclk)
	begin
		if (rx_store)
			rx_mem[rx_rd_ptr_reg ^ rx_count_reg[0]] <= rx_new;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !rx_on)
		begin
			rx_count_reg <= 2'd0;
			rx_rd_ptr_reg <= 1'b0;
			overrun_flag_reg <= 1'b0;
		end
		else
		begin
			if (rx_push && rx_count_reg == 2'(rx_depth) && !rx_pop)
				overrun_flag_reg <= 1'b1;
			else if (status_seen_reg && (rd_data || wr_data))
				overrun_flag_reg <= 1'b0;
			if (rx_pop)
				rx_rd_ptr_reg <= !rx_rd_ptr_reg;
			case ({rx_store, rx_pop})
				2'b10: rx_count_reg <= rx_count_reg + 2'd1;
				2'b01: rx_count_reg <= rx_count_reg - 2'd1;
				default: rx_count_reg <= rx_count_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Pins and interrupt
	// ----------------------------------------
	assign tx_oe = tx_on;
	assign rx_in_used = rx_on;
	assign irq = ctrl2_reg[receive_irq_on_pos] && (rx_count_reg != 2'd0 || overrun_flag_reg);

	property p_tx_empty_on_load;
		@(posedge aclk) disable iff (!aresetn) tx_load && tx_on |=> tx_empty_reg;
	endproperty
	a_tx_empty_on_load: assert property (p_tx_empty_on_load) else $error("empty not set on load");

	property p_off_floats;
		@(posedge aclk) disable iff (!aresetn) !unit_on |-> !tx_oe && !rx_in_used;
	endproperty
	a_off_floats: assert property (p_off_floats) else $error("lines driven while off");

	property p_off_flags;
		@(posedge aclk) disable iff (!aresetn) !unit_on ##1 !unit_on |-> tx_empty_reg && tx_quiet_reg
			&& rx_quiet_reg && rx_count_reg == 2'd0 && !overrun_flag_reg;
	endproperty
	a_off_flags: assert property (p_off_flags) else $error("flags wrong while off");

	property p_quiet_line_high;
		@(posedge aclk) disable iff (!aresetn) tx_quiet_reg && tx_on && tx_state_reg == tx_idle |-> tx_out;
	endproperty
	a_quiet_line_high: assert property (p_quiet_line_high) else $error("line low while quiet");

	property p_no_quiet_queued;
		@(posedge aclk) disable iff (!aresetn) tx_on && tx_full_reg ##1 tx_on |-> !tx_quiet_reg;
	endproperty
	a_no_quiet_queued: assert property (p_no_quiet_queued) else $error("quiet while queued");

	property p_rx_busy;
		@(posedge aclk) disable iff (!aresetn) rx_state_reg == rx_bits |-> !rx_quiet_reg;
	endproperty
	a_rx_busy: assert property (p_rx_busy) else $error("receive quiet during frame");

	property p_break_len;
		@(posedge aclk) disable iff (!aresetn) tx_state_reg == tx_brk && tx_idx_reg != 5'd0 |-> !tx_out;
	endproperty
	a_break_len: assert property (p_break_len) else $error("break line high");

	property p_push_ready;
		@(posedge aclk) disable iff (!aresetn) rx_push && !rx_pop && rx_count_reg == 2'd0 |=> rx_count_reg == 2'd1;
	endproperty
	a_push_ready: assert property (p_push_ready) else $error("ready not set on word");

endmodule : serial_port

// ==== src/serial_port_pkg.sv ====
package serial_port_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [3:0] status_addr = 4'h0;
	localparam logic [3:0] frame_ctrl_addr = 4'h4;
	localparam logic [3:0] second_ctrl_addr = 4'h8;
	localparam logic [3:0] data_addr = 4'hc;
	localparam logic [3:0] baud_addr = 4'h0 + 4'h0;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int parity_error_flag_pos = 7;
	localparam int noise_pos = 6;
	localparam int framing_error_flag_pos = 5;
	localparam int overrun_flag_pos = 4;
	localparam int rx_quiet_pos = 3;
	localparam int rx_ready_pos = 2;
	localparam int tx_quiet_pos = 1;
	localparam int tx_empty_pos = 0;

	// ----------------------------------------
	// Frame control field positions
	// ----------------------------------------
	localparam int unit_on_pos = 7;
	localparam int nine_bit_pos = 6;
	localparam int parity_on_pos = 5;
	localparam int parity_odd_pos = 4;
	localparam int two_stop_pos = 3;
	localparam int send_break_pos = 2;
	localparam int rx_ninth_pos = 1;
	localparam int tx_ninth_pos = 0;

	// ----------------------------------------
	// Second control field positions
	// ----------------------------------------
	localparam int transmitter_on_pos = 7;
	localparam int receiver_on_pos = 6;
	localparam int high_speed_pos = 5;
	localparam int receive_irq_on_pos = 2;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] frame_ctrl_reset = 8'h00;
	localparam logic [7:0] second_ctrl_reset = 8'h00;
	localparam logic [7:0] baud_reset = 8'h00;
	localparam int break_bits = 13;
	localparam int low_speed_div = 64;
	localparam int high_speed_div = 16;
	localparam int rx_depth = 2;

	typedef enum logic [1:0] {resp_okay = 2'b00, resp_slverr = 2'b10} axi_resp_e;

	typedef struct packed {
		logic parity_err;
		logic noise;
		logic framing_err;
		logic ninth;
		logic [7:0] data;
	} rx_word_s;

endpackage : serial_port_pkg

// ==== test/remote_node.sv ====
`timescale 1ns/1ps
module remote_node
(
	input wire logic aclk,
	input wire logic tx_line,
	input wire logic tx_en,
	input wire logic [7:0] cfg,
	output logic rx_line,
	output logic [8:0] got_word,
	output logic got_err,
	output int got_count
);
	parameter int bit_ns = 160;
	logic [8:0] w;
	logic ok;

	initial
	begin
		rx_line = 1'b1;
		got_word = 9'h000;
		got_err = 1'b0;
		got_count = 0;
	end

	// ----------------------------------------
	// Frame sender, transitions off the clock edge
	// ----------------------------------------
	task automatic send_frame(input logic [8:0] d, input logic [7:0] c, input logic bad_par, input logic bad_stop);
		logic [8:0] v;
		v = c[6] ? d : {1'b0, d[7:0]};
		@(negedge aclk);
		rx_line = 1'b0;
		#(bit_ns);
		for (int i = 0; i < (c[6] ? 9 : 8); i++)
		begin
			rx_line = v[i];
			#(bit_ns);
		end
		if (c[5])
		begin
			rx_line = (^v) ^ c[4] ^ bad_par;
			#(bit_ns);
		end
		rx_line = ~bad_stop;
		#(bit_ns);
		rx_line = 1'b1;
		if (c[3])
			#(bit_ns);
	endtask : send_frame

	// ----------------------------------------
	// Frame decoder, samples mid bit
	// ----------------------------------------
	always
	begin
		@(negedge tx_line iff tx_en === 1'b1);
		#(bit_ns / 2);
		w = 9'h000;
		ok = (tx_line === 1'b0);
		for (int i = 0; i < (cfg[6] ? 9 : 8); i++)
		begin
			#(bit_ns);
			w[i] = tx_line;
		end
		if (cfg[5])
		begin
			#(bit_ns);
			ok &= (((^w) ^ tx_line) === cfg[4]);
		end
		#(bit_ns);
		ok &= (tx_line === 1'b1);
		if (cfg[3])
		begin
			#(bit_ns);
			ok &= (tx_line === 1'b1);
		end
		got_word = w;
		got_err = ~ok;
		got_count++;
	end
endmodule : remote_node

// ==== test/uart_status_and_frame_control_tb.sv ====
`timescale 1ns/1ps
module uart_status_and_frame_control_tb
	import serial_port_pkg::*;
;
	localparam int bit_cyc = high_speed_div;
	logic aclk;
	logic aresetn;
	logic [3:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [3:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	logic rx_in;
	logic rx_in_used;
	logic tx_out;
	logic tx_oe;
	logic irq;
	logic [7:0] node_cfg;
	logic [8:0] node_word;
	logic node_err;
	int node_count;
	int num_errors = 0;
	int checks = 0;
	logic [7:0] s;
	int base;
	int n;
	logic [7:0] tx_modes [5] = '{8'h80, 8'ha0, 8'hb0, 8'hf9, 8'hc8};
	logic [7:0] e_cfg [4] = '{8'hb0, 8'ha0, 8'h80, 8'hc0};
	logic [8:0] e_word [4] = '{9'h0e1, 9'h011, 9'h07e, 9'h1a5};
	logic [1:0] e_bad [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
	logic [7:0] e_stat [4] = '{8'h8f, 8'h8f, 8'h2f, 8'h0f};

	serial_port u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.rx_in(rx_in), .rx_in_used(rx_in_used), .tx_out(tx_out), .tx_oe(tx_oe), .irq(irq));

	remote_node #(.bit_ns(bit_cyc * 10)) u_node (.aclk(aclk), .tx_line(tx_out), .tx_en(tx_oe), .cfg(node_cfg),
		.rx_line(rx_in), .got_word(node_word), .got_err(node_err), .got_count(node_count));

	always #5 aclk = ~aclk;

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic fail_to;
		num_errors++;
		$display("CHECK FAILED t=%0t wait limit reached", $time);
		final_report();
	endtask : fail_to

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// ----------------------------------------
	// Register bus cycles
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int k;
		logic aw;
		logic w;
		k = 0;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while ((aw || w) && k < 50)
		begin
			@(posedge aclk);
			k++;
			if (aw && s_axi_awready === 1'b1)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_bvalid !== 1'b1 && k < 100);
		s_axi_bready <= 1'b0;
		if (k >= 100)
			fail_to();
		chk({30'h0, s_axi_bresp}, {30'h0, resp_okay}, "write response");
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_arready !== 1'b1 && k < 50);
		s_axi_arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			k++;
		end
		while (s_axi_rvalid !== 1'b1 && k < 100);
		d = s_axi_rdata[7:0];
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, resp_okay}, "read response");
		if (k >= 100)
			fail_to();
	endtask : rd

	task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		rd(a, d);
		chk(d, e, m);
	endtask : rchk

	task automatic wait_node(input int target);
		int k;
		k = 0;
		while (node_count < target && k < 4000)
		begin
			@(posedge aclk);
			k++;
		end
		if (k >= 4000)
			fail_to();
	endtask : wait_node

	initial
	begin
		repeat (100000) @(posedge aclk);
		fail_to();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		s_axi_awaddr = 4'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 4'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		node_cfg = 8'h80;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(status_addr, 8'h0b, "status reset");
		rchk(frame_ctrl_addr, frame_ctrl_reset, "frame control reset");
		rchk(second_ctrl_addr, second_ctrl_reset, "second control reset");
		chk(tx_oe, 1'b0, "line driven while off");
		wr(frame_ctrl_addr, 8'h80);
		wr(second_ctrl_addr, 8'he4);
		chk({tx_oe, rx_in_used}, 2'b11, "lines follow enables");
		rchk(status_addr, 8'h0b, "status after enable");
		// Transmit in five frame formats, two words back to back
		for (int i = 0; i < 5; i++)
		begin
			node_cfg <= tx_modes[i];
			wr(frame_ctrl_addr, tx_modes[i]);
			base = node_count;
			rd(status_addr, s);
			wr(data_addr, 8'h3c + i[7:0]);
			repeat (bit_cyc) @(posedge aclk);
			rd(status_addr, s);
			chk(s[1:0], 2'b01, "flags after first word");
			wr(data_addr, 8'hc5 - i[7:0]);
			rd(status_addr, s);
			chk(s[1:0], 2'b00, "flags with word queued");
			wait_node(base + 1);
			chk(node_word, {tx_modes[i][6] & tx_modes[i][0], 8'h3c + i[7:0]}, "first word");
			chk(node_err, 1'b0, "first frame format");
			wait_node(base + 2);
			chk(node_word, {tx_modes[i][6] & tx_modes[i][0], 8'hc5 - i[7:0]}, "second word");
			chk(node_err, 1'b0, "second frame format");
			repeat (2 * bit_cyc) @(posedge aclk);
			rchk(status_addr, 8'h0b, "status after transmit");
		end
		// Break after a buffered word
		node_cfg <= 8'h80;
		wr(frame_ctrl_addr, 8'h80);
		base = node_count;
		rd(status_addr, s);
		wr(data_addr, 8'h55);
		wr(frame_ctrl_addr, 8'h84);
		wait_node(base + 1);
		chk(node_word, 9'h055, "word before break");
		n = 0;
		while (tx_out !== 1'b0 && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
		base = 0;
		repeat (break_bits * bit_cyc)
		begin
			@(posedge aclk);
			base += (tx_out === 1'b0);
		end
		chk(base, break_bits * bit_cyc, "break length");
		rd(status_addr, s);
		chk(s[1], 1'b0, "quiet during break");
		wr(frame_ctrl_addr, 8'h80);
		n = 0;
		while (tx_out !== 1'b1 && n < 400)
		begin
			@(posedge aclk);
			n++;
		end
		chk(tx_out, 1'b1, "line after break");
		// Receive two words back to back
		fork
			begin
				u_node.send_frame(9'h05a, 8'h80, 1'b0, 1'b0);
				u_node.send_frame(9'h0c3, 8'h80, 1'b0, 1'b0);
			end
			begin
				repeat (4 * bit_cyc) @(posedge aclk);
				rd(status_addr, s);
				chk(s[3], 1'b0, "receive busy flag");
			end
		join
		repeat (2 * bit_cyc) @(posedge aclk);
		chk(irq, 1'b1, "receive request");
		rchk(status_addr, 8'h0f, "status two words");
		rchk(data_addr, 8'h5a, "first received");
		rchk(status_addr, 8'h0f, "ready with word left");
		rchk(data_addr, 8'hc3, "second received");
		rchk(status_addr, 8'h0b, "ready cleared");
		chk(irq, 1'b0, "request dropped");
		// Received errors and ninth bit
		for (int i = 0; i < 4; i++)
		begin
			wr(frame_ctrl_addr, e_cfg[i]);
			u_node.send_frame(e_word[i], e_cfg[i], e_bad[i][1], e_bad[i][0]);
			repeat (2 * bit_cyc) @(posedge aclk);
			if (e_cfg[i][6])
				rchk(frame_ctrl_addr, e_cfg[i] | {6'h00, e_word[i][8], 1'b0}, "received ninth");
			rchk(status_addr, e_stat[i], "error with ready");
			rchk(data_addr, e_word[i][7:0], "error word");
			rchk(status_addr, 8'h0b, "errors cleared");
		end
		// Disable in mid transmission, then resume
		node_cfg <= 8'hb8;
		wr(frame_ctrl_addr, 8'hb8);
		rd(status_addr, s);
		wr(data_addr, 8'h99);
		rd(status_addr, s);
		wr(data_addr, 8'h77);
		repeat (3 * bit_cyc) @(posedge aclk);
		wr(frame_ctrl_addr, 8'h38);
		chk({tx_oe, rx_in_used}, 2'b00, "lines float");
		rchk(status_addr, 8'h0b, "status on disable");
		rchk(second_ctrl_addr, 8'h24, "enables cleared");
		rd(frame_ctrl_addr, s);
		chk(s & 8'hfd, 8'h38, "config kept");
		repeat (14 * bit_cyc) @(posedge aclk);
		wr(frame_ctrl_addr, 8'hb8);
		wr(second_ctrl_addr, 8'he4);
		rchk(status_addr, 8'h0b, "status on resume");
		base = node_count;
		wr(data_addr, 8'h66);
		wait_node(base + 1);
		chk(node_word, 9'h066, "no stale word");
		chk(node_err, 1'b0, "resumed format");
		final_report();
	end
endmodule : uart_status_and_frame_control_tb
